/* hdl/omg_delin.sv */
// Core header hunt and sync delineation on the receive side.
`timescale 1ns/10ps
`include "omg_params.svh"

module omg_delin
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core header check results, one strobe per header
  input wire logic hdr_strobe,
  input wire logic hdr_ok,
  input wire logic [3:0] header_sync_threshold,
  // Delineation state
  output logic in_sync
);

  omg_pkg::omg_delin_state_type s;
  omg_pkg::omg_delin_state_type next_s;
  logic [4:0] thr;

  // A threshold of zero behaves as one, since sync needs at least one good header.
  assign thr = (header_sync_threshold == 4'h0) ? 5'h01 : {1'b0, header_sync_threshold};

  // Hunt counts an unbroken run of good headers; one bad header in sync drops back.
  always_comb
  begin
    next_s = s;
    case (s.phase)
      omg_pkg::omg_hunt:
      begin
        if (hdr_strobe && hdr_ok)
        begin
          if (s.run + 5'h01 >= thr)
          begin
            next_s.phase = omg_pkg::omg_sync; // see R18
            next_s.run = 5'h00;
          end
          else
          begin
            next_s.run = s.run + 5'h01;
          end
        end
        else if (hdr_strobe)
        begin
          next_s.run = 5'h00; // see R20
        end
      end
      omg_pkg::omg_sync:
      begin
        if (hdr_strobe && !hdr_ok)
        begin
          next_s.phase = omg_pkg::omg_hunt;
          next_s.run = 5'h00;
        end
      end
      default:
      begin
        next_s.phase = omg_pkg::omg_hunt;
        next_s.run = 5'h00;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s.phase <= omg_pkg::omg_hunt;
      s.run <= 5'h00;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign in_sync = (s.phase == omg_pkg::omg_sync);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence bad_in_hunt;
    (s.phase == omg_pkg::omg_hunt) && hdr_strobe && !hdr_ok;
  endsequence

  hunt_run_clear_a: assert property (@(posedge clk) disable iff (rst) // see R20
    bad_in_hunt |=> (s.run == 5'h00) && !in_sync)
    else $error("Run counter not cleared by a bad header.");

  sync_entry_a: assert property (@(posedge clk) disable iff (rst) // see R18
    $rose(in_sync) |-> $past(hdr_strobe) && $past(hdr_ok) && ($past(s.run) + 5'h01 >= $past(thr)))
    else $error("Sync entered without a full run of good headers.");

endmodule : omg_delin

/* hdl/omg_mapper.sv */
// Transmit overhead, tributary filling and generic framing mapper with register slave.
`timescale 1ns/10ps
`include "omg_params.svh"

// Summary of operation
// R1 - Status byte bit 5 follows sink signal fail.
// R2 - Bits 6-8 carry only legal maintenance codes.
// R3 - Four protection bytes, request then type nibble.
// R4 - Request nibble limited to defined codes only.
// R5 - Payload identifier byte carries the payload type.
// R6 - Test payloads labelled null or pseudo-random.
// R7 - Multiplexed payload labelled asynchronous-only or generic.
// R8 - Unavailable payload codes never sent; 0x80 proprietary.
// R9 - Target tributary slots carry the measured unit.
// R10 - Copy mode repeats target in other slots.
// R11 - Unused mode fills other slots pseudo-randomly.
// R12 - Block substitution sends link error code.
// R13 - Frame substitution sends idle plus periodic fail.
// R14 - Payload type 100 makes management frames.
// R15 - Check flag adds or drops frame check.
// R16 - Four-bit extension identifier, zero means null.
// R17 - Eight-bit user payload identifier is sent.
// R18 - Sync only after threshold good headers.
// R19 - Error counts above eight are sent zero.
// R20 - Any bad header in hunt clears run.
module omg_mapper
#(
  parameter int unsigned CSF_PERIOD_CYC = `OMG_CSF_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Register bus write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Register bus read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Path and client status
  input wire logic sink_signal_fail,
  input wire logic client_fail,
  // Tributary source
  input wire logic trib_byte_en,
  input wire logic [7:0] trib_target_byte,
  // Transparent framing client stream
  input wire logic [9:0] client_10b,
  // Receive core header checks
  input wire logic hdr_strobe,
  input wire logic hdr_ok,
  // Overhead outputs
  output logic [7:0] pm_byte,
  output logic [31:0] aps_bytes,
  output logic [7:0] psi_byte,
  // Tributary slot outputs, slot n in bits 8n+7 down to 8n
  output logic [63:0] trib_slot_data,
  // Transparent framing outputs
  output logic [9:0] gfpt_data,
  output logic gfpt_idle,
  output logic gfpt_csf_pulse,
  // Frame-mapped framing outputs
  output logic [15:0] gfpf_header,
  output logic gfpf_mgmt_frame,
  output logic gfpf_fcs_en,
  // Receive delineation state
  output logic hdr_in_sync
);

  omg_pkg::omg_map_state_type s;
  omg_pkg::omg_map_state_type next_s;
  logic [7:0] prbs_byte;
  logic [63:0] slot_mux;
  logic frame_mode;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Byte-lane merge of a write into the old register value.
  function automatic logic [31:0] omg_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : omg_merge

  // Legal maintenance codes; the rest are reserved.
  function automatic logic omg_stat_ok(input logic [2:0] c);
    return (c == `OMG_STAT_NORMAL) || (c == `OMG_STAT_LCK) ||
           (c == `OMG_STAT_OCI) || (c == `OMG_STAT_AIS);
  endfunction : omg_stat_ok

  // Defined protection requests; the rest are reserved.
  function automatic logic omg_req_ok(input logic [3:0] c);
    logic ok;
    case (c)
      `OMG_REQ_NR, `OMG_REQ_DNR, `OMG_REQ_RR, `OMG_REQ_EXER, `OMG_REQ_WTR,
      `OMG_REQ_MS, `OMG_REQ_SD, `OMG_REQ_SF, `OMG_REQ_FS, `OMG_REQ_LO: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : omg_req_ok

  // Codes that must never be sent as a payload type.
  function automatic logic omg_psi_bad(input logic [7:0] c);
    return (c == `OMG_PSI_NA0) || (c == `OMG_PSI_NA1) || (c == `OMG_PSI_NA2);
  endfunction : omg_psi_bad

  // ----------------------------------------------------------------------
  // Tributary filling and helpers
  // ----------------------------------------------------------------------
  omg_prbs u_prbs
  (
    .clk(clk),
    .rst(rst),
    .step(trib_byte_en),
    .data(prbs_byte)
  );

  omg_delin u_delin
  (
    .clk(clk),
    .rst(rst),
    .hdr_strobe(hdr_strobe),
    .hdr_ok(hdr_ok),
    .header_sync_threshold(s.gfp[`OMG_GFP_THR]),
    .in_sync(hdr_in_sync)
  );

  // Each slot takes the target when selected, else the copy or the pseudo-random filler.
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_slot
      assign slot_mux[i*8 +: 8] = s.trib[i] ? trib_target_byte : // see R9
                                  s.trib[`OMG_TRIB_COPY] ? trib_target_byte : // see R10
                                  prbs_byte; // see R11
    end
  endgenerate

  assign frame_mode = s.gfp[`OMG_GFP_CSF];

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Bus handshake, register writes and all registered outputs except hdr_in_sync.
  always_comb
  begin
    logic [31:0] wd;
    logic [7:0] code;
    wd = 32'h0000_0000;
    code = 8'h00;
    next_s = s;
    next_s.csf_pulse = 1'b0;

    // Address and data are taken in either order; the response follows both.
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `OMG_RESP_OKAY;
      case (s.awaddr)
        `OMG_REG_PM:
        begin
          wd = omg_merge(s.pm, s.wdata, s.wstrb);
          if (!omg_stat_ok(wd[`OMG_PM_STAT]))
          begin
            wd[`OMG_PM_STAT] = s.pm[`OMG_PM_STAT]; // see R2
          end
          next_s.pm = wd;
        end
        `OMG_REG_APS:
        begin
          wd = omg_merge(s.aps, s.wdata, s.wstrb);
          if (!omg_req_ok(wd[`OMG_APS_REQ]))
          begin
            wd[`OMG_APS_REQ] = s.aps[`OMG_APS_REQ]; // see R4
          end
          next_s.aps = wd;
        end
        `OMG_REG_PSI:
        begin
          wd = omg_merge(s.psi, s.wdata, s.wstrb);
          if (omg_psi_bad(wd[`OMG_PSI_CODE]))
          begin
            wd[`OMG_PSI_CODE] = s.psi[`OMG_PSI_CODE]; // see R8
          end
          next_s.psi = wd;
        end
        `OMG_REG_TRIB: next_s.trib = omg_merge(s.trib, s.wdata, s.wstrb);
        `OMG_REG_GFP: next_s.gfp = omg_merge(s.gfp, s.wdata, s.wstrb);
        `OMG_REG_STAT: next_s.bresp = `OMG_RESP_OKAY;
        default: next_s.bresp = `OMG_RESP_SLVERR;
      endcase
    end

    // Reads answer one cycle after the address is taken.
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `OMG_RESP_OKAY;
      case (s_axi_araddr)
        `OMG_REG_PM: next_s.rdata = s.pm;
        `OMG_REG_APS: next_s.rdata = s.aps;
        `OMG_REG_PSI: next_s.rdata = s.psi;
        `OMG_REG_TRIB: next_s.rdata = s.trib;
        `OMG_REG_GFP: next_s.rdata = s.gfp;
        `OMG_REG_STAT: next_s.rdata = {14'h0000, client_fail, hdr_in_sync, s.psi_out, s.pm_byte};
        default:
        begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `OMG_RESP_SLVERR;
        end
      endcase
    end

    // Path status byte: error count, defect flag, maintenance code.
    next_s.pm_byte[7:4] = (s.pm[`OMG_PM_BEI] > `OMG_BEI_MAX) ? `OMG_BEI_ZERO :
                          s.pm[`OMG_PM_BEI]; // see R19
    next_s.pm_byte[3] = sink_signal_fail; // see R1
    next_s.pm_byte[2:0] = s.pm[`OMG_PM_STAT]; // see R2
    next_s.aps_out = s.aps; // see R3

    // Test and multiplex labels override the configured payload type.
    code = s.psi[`OMG_PSI_CODE]; // see R5
    if (s.psi[`OMG_PSI_TEST] == `OMG_TEST_NULL)
    begin
      code = `OMG_PSI_NULL; // see R6
    end
    else if (s.psi[`OMG_PSI_TEST] == `OMG_TEST_PRBS)
    begin
      code = `OMG_PSI_PRBS; // see R6
    end
    else if (s.psi[`OMG_PSI_MUX] == `OMG_MUX_AMP)
    begin
      code = `OMG_PSI_AMP; // see R7
    end
    else if (s.psi[`OMG_PSI_MUX] == `OMG_MUX_GMP)
    begin
      code = `OMG_PSI_GMP; // see R7
    end
    next_s.psi_out = code;

    if (trib_byte_en)
    begin
      next_s.trib_out = slot_mux;
    end

    // Transparent path; the fail frame is sent on entry and then once per period.
    next_s.gfpt_idle = 1'b0;
    next_s.gfpt_out = client_10b;
    if (client_fail && frame_mode)
    begin
      next_s.gfpt_idle = 1'b1; // see R13
      next_s.gfpt_out = 10'h000;
      if (s.csf_cnt == 32'h0000_0000)
      begin
        next_s.csf_pulse = 1'b1; // see R13
        next_s.csf_cnt = 32'(CSF_PERIOD_CYC - 1);
      end
      else
      begin
        next_s.csf_cnt = s.csf_cnt - 32'h0000_0001;
      end
    end
    else
    begin
      next_s.csf_cnt = 32'h0000_0000;
      if (client_fail)
      begin
        next_s.gfpt_out = `OMG_LINK_ERR_10B; // see R12
      end
    end

    // Frame-mapped header: type, check flag, extension, user identifier.
    next_s.gfpf_hdr = {s.gfp[`OMG_GFP_PTI], s.gfp[`OMG_GFP_PFI], s.gfp[`OMG_GFP_EXI],
                       s.gfp[`OMG_GFP_UPI]}; // see R14, R15, R16, R17
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Everything resets to constants; the output bytes start from register defaults.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.pm <= `OMG_RST_PM;
      s.aps <= `OMG_RST_APS;
      s.psi <= `OMG_RST_PSI;
      s.trib <= `OMG_RST_TRIB;
      s.gfp <= `OMG_RST_GFP;
      s.pm_byte <= {`OMG_BEI_ZERO, 1'b0, `OMG_STAT_NORMAL};
      s.psi_out <= 8'(`OMG_RST_PSI);
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Ready is withheld while a response is pending, so only one write is open.
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign pm_byte = s.pm_byte;
  assign aps_bytes = s.aps_out;
  assign psi_byte = s.psi_out;
  assign trib_slot_data = s.trib_out;
  assign gfpt_data = s.gfpt_out;
  assign gfpt_idle = s.gfpt_idle;
  assign gfpt_csf_pulse = s.csf_pulse;
  assign gfpf_header = s.gfpf_hdr;
  assign gfpf_mgmt_frame = (s.gfpf_hdr[15:13] == `OMG_PTI_MGMT); // see R14
  assign gfpf_fcs_en = s.gfpf_hdr[12]; // see R15

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence fail_frame_entry;
    !(client_fail && frame_mode) ##1 (client_fail && frame_mode);
  endsequence

  defect_flag_a: assert property (@(posedge clk) disable iff (rst) // see R1
    !$past(rst) |-> pm_byte[3] == $past(sink_signal_fail))
    else $error("Defect flag does not follow sink fail.");

  stat_legal_a: assert property (@(posedge clk) disable iff (rst) // see R2
    omg_stat_ok(pm_byte[2:0]))
    else $error("Reserved maintenance code sent.");

  request_legal_a: assert property (@(posedge clk) disable iff (rst) // see R4
    omg_req_ok(aps_bytes[31:28]))
    else $error("Reserved protection request sent.");

  psi_avail_a: assert property (@(posedge clk) disable iff (rst) // see R8
    !omg_psi_bad(psi_byte))
    else $error("Unavailable payload type sent.");

  psi_test_a: assert property (@(posedge clk) disable iff (rst) // see R6
    (s.psi[`OMG_PSI_TEST] == `OMG_TEST_PRBS) |=> psi_byte == `OMG_PSI_PRBS)
    else $error("Pseudo-random test payload mislabelled.");

  bei_clamp_a: assert property (@(posedge clk) disable iff (rst) // see R19
    pm_byte[7:4] <= `OMG_BEI_MAX)
    else $error("Error count above eight sent.");

  slot_copy_a: assert property (@(posedge clk) disable iff (rst) // see R10
    trib_byte_en && s.trib[`OMG_TRIB_COPY] |=> trib_slot_data == {8{$past(trib_target_byte)}})
    else $error("Copy filler slots differ from target.");

  block_sub_a: assert property (@(posedge clk) disable iff (rst) // see R12
    client_fail && !frame_mode |=> gfpt_data == `OMG_LINK_ERR_10B && !gfpt_idle)
    else $error("Link error code not sent on client fail.");

  csf_first_a: assert property (@(posedge clk) disable iff (rst) // see R13
    fail_frame_entry |=> gfpt_csf_pulse && gfpt_idle)
    else $error("Fail frame not sent on entering frame substitution.");

  mgmt_frame_a: assert property (@(posedge clk) disable iff (rst) // see R14
    (s.gfp[`OMG_GFP_PTI] == `OMG_PTI_MGMT) ##1 (s.gfp[`OMG_GFP_PTI] == `OMG_PTI_MGMT)
    |-> gfpf_mgmt_frame)
    else $error("Management type set but frames not marked management.");

endmodule : omg_mapper

/* hdl/omg_prbs.sv */
// Byte-wide pseudo-random filler generator for unused tributaries.
`timescale 1ns/10ps
`include "omg_params.svh"

module omg_prbs
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Step control and output
  input wire logic step,
  output logic [7:0] data
);

  omg_pkg::omg_prbs_state_type s;
  omg_pkg::omg_prbs_state_type next_s;

  // Eight shifts of a nine-stage sequence per step, so each step gives a fresh byte shared by all filler slots.
  always_comb
  begin
    logic [8:0] l;
    logic fb;
    l = s.lfsr;
    fb = 1'b0;
    next_s = s;
    if (step)
    begin
      for (int k = 0; k < 8; k++)
      begin
        fb = l[8] ^ l[4];
        l = {l[7:0], fb};
        next_s.data[k] = fb;
      end
      next_s.lfsr = l;
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s.lfsr <= `OMG_PRBS_SEED;
      s.data <= 8'h00;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign data = s.data;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  prbs_alive_a: assert property (@(posedge clk) disable iff (rst) // see R11
    s.lfsr != 9'h000)
    else $error("Filler sequence register stuck at zero.");

endmodule : omg_prbs

/* shared/omg_params.svh */
// Constants for the transport overhead and generic framing mapper.
`ifndef OMG_PARAMS_SVH
`define OMG_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map and field positions
// ----------------------------------------------------------------------
`define OMG_ADDR_W 8
`define OMG_REG_PM 8'h00
`define OMG_REG_APS 8'h04
`define OMG_REG_PSI 8'h08
`define OMG_REG_TRIB 8'h0C
`define OMG_REG_GFP 8'h10
`define OMG_REG_STAT 8'h14
`define OMG_PM_BEI 3:0
`define OMG_PM_STAT 6:4
`define OMG_APS_REQ 31:28
`define OMG_APS_TYPE 27:24
`define OMG_PSI_CODE 7:0
`define OMG_PSI_TEST 9:8
`define OMG_PSI_MUX 11:10
`define OMG_TRIB_MASK 7:0
`define OMG_TRIB_COPY 8
`define OMG_GFP_PTI 2:0
`define OMG_GFP_PFI 3
`define OMG_GFP_EXI 7:4
`define OMG_GFP_UPI 15:8
`define OMG_GFP_CSF 16
`define OMG_GFP_THR 23:20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OMG_RST_PM 32'h0000_0010
`define OMG_RST_APS 32'h0000_0000
`define OMG_RST_PSI 32'h0000_0005
`define OMG_RST_TRIB 32'h0000_0001
`define OMG_RST_GFP 32'h0010_0100

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define OMG_BEI_MAX 4'h8
`define OMG_BEI_ZERO 4'h0
`define OMG_STAT_NORMAL 3'h1
`define OMG_STAT_LCK 3'h5
`define OMG_STAT_OCI 3'h6
`define OMG_STAT_AIS 3'h7
`define OMG_REQ_NR 4'h0
`define OMG_REQ_DNR 4'h1
`define OMG_REQ_RR 4'h2
`define OMG_REQ_EXER 4'h4
`define OMG_REQ_WTR 4'h6
`define OMG_REQ_MS 4'h8
`define OMG_REQ_SD 4'hA
`define OMG_REQ_SF 4'hC
`define OMG_REQ_FS 4'hE
`define OMG_REQ_LO 4'hF
`define OMG_PSI_NA0 8'h55
`define OMG_PSI_NA1 8'h66
`define OMG_PSI_NA2 8'hFF
`define OMG_PSI_NULL 8'hFD
`define OMG_PSI_PRBS 8'hFE
`define OMG_PSI_AMP 8'h20
`define OMG_PSI_GMP 8'h21
`define OMG_TEST_NULL 2'h1
`define OMG_TEST_PRBS 2'h2
`define OMG_MUX_AMP 2'h1
`define OMG_MUX_GMP 2'h2
`define OMG_PTI_MGMT 3'h4
`define OMG_LINK_ERR_10B 10'h2AA
`define OMG_RESP_OKAY 2'h0
`define OMG_RESP_SLVERR 2'h2
`define OMG_PRBS_SEED 9'h1FF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define OMG_CLK_HZ 125000000
`define OMG_CSF_PERIOD_MS 500
`define OMG_CSF_PERIOD_CYC (`OMG_CSF_PERIOD_MS * (`OMG_CLK_HZ / 1000))

`endif

/* shared/omg_pkg.sv */
// State types for the transport overhead and generic framing mapper.
package omg_pkg;

  // Core header delineation phases.
  typedef enum logic [0:0] {omg_hunt, omg_sync} omg_phase_type;

  typedef struct packed {
    omg_phase_type phase;
    logic [4:0] run;
  } omg_delin_state_type;

  typedef struct packed {
    logic [8:0] lfsr;
    logic [7:0] data;
  } omg_prbs_state_type;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] pm;
    logic [31:0] aps;
    logic [31:0] psi;
    logic [31:0] trib;
    logic [31:0] gfp;
    logic [31:0] csf_cnt;
    logic [7:0] pm_byte;
    logic [31:0] aps_out;
    logic [7:0] psi_out;
    logic [63:0] trib_out;
    logic [9:0] gfpt_out;
    logic gfpt_idle;
    logic csf_pulse;
    logic [15:0] gfpf_hdr;
  } omg_map_state_type;

endpackage : omg_pkg

/* verification/omg_far_end.sv */
// Far-end model that sends received core header check verdicts.
`timescale 1ns/10ps

module omg_far_end
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Header request and verdict
  input wire logic send,
  input wire logic good,
  output logic hdr_strobe,
  output logic hdr_ok
);
  // One header per request; between headers the verdict flips so a stale value never helps.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hdr_strobe <= 1'h0;
      hdr_ok <= 1'h0;
    end
    else
    begin
      hdr_strobe <= send;
      hdr_ok <= send ? good : !hdr_ok;
    end
  end
endmodule : omg_far_end

/* verification/otn_overhead_gfp_mapper_tb.sv */
// Self-checking bench for the overhead and framing mapper.
`timescale 1ns/10ps

module otn_overhead_gfp_mapper_tb;
  typedef struct packed {logic [7:0] a; logic [33:0] v;} omg_note_type;
  logic clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, sink = 1'h0, send = 1'h0, good = 1'h0, hs, hk, awready, wready;
  logic bvalid, arready, rvalid, sync, cf = 1'h0, ten = 1'h0, gi, gp, mg, fe;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pm, psi, psi_now, tv = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, x, aps;
  logic [1:0] bresp, rresp;
  logic [9:0] c10 = 10'h000, gt;
  logic [15:0] gh;
  logic [63:0] ts;
  logic [2:0] cur;
  logic [3:0] c;
  logic [3:0] reqs [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE, 4'hF};
  logic [31:0] pw [7] = '{32'h7, 32'h55, 32'h100, 32'h200, 32'h400, 32'h800, 32'h80};
  logic [7:0] pe [7] = '{8'h07, 8'h07, 8'hFD, 8'hFE, 8'h20, 8'h21, 8'h80};
  omg_note_type q [$];
  omg_note_type e;
  int n_fail = 0, n_checks = 0, cyc = 0;

  omg_mapper #(.CSF_PERIOD_CYC(20)) i_omg_mapper (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sink_signal_fail(sink), .client_fail(cf), .trib_byte_en(ten),
    .trib_target_byte(tv), .client_10b(c10), .hdr_strobe(hs), .hdr_ok(hk),
    .pm_byte(pm), .aps_bytes(aps), .psi_byte(psi), .trib_slot_data(ts), .gfpt_data(gt),
    .gfpt_idle(gi), .gfpt_csf_pulse(gp), .gfpf_header(gh), .gfpf_mgmt_frame(mg),
    .gfpf_fcs_en(fe), .hdr_in_sync(sync));
  omg_far_end i_omg_far_end (.clk(clk), .rst(rst), .send(send), .good(good),
    .hdr_strobe(hs), .hdr_ok(hk));

  // Clock at 125 MHz and a free-running random client stream.
  initial
  begin
    forever #4 clk = !clk;
  end
  always @(posedge clk) c10 <= 10'($urandom);

  task automatic check(input logic [7:0] a, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected reg %h expected %h seen %h", a, exp, seen);
    end
  endtask : check

  // Read and write responses are compared as they appear, against the oldest note.
  always @(posedge clk)
  begin
    if (((rvalid && rready) || (bvalid && bready)) && q.size() > 0)
    begin
      e = q.pop_front();
      check(e.a, rvalid ? {rresp, rdata} : {bresp, 32'h0}, e.v);
    end
  end

  // Write and read masters hold each valid until its own ready, and each response ready until its valid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    q.push_back({a, 34'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) bready <= 1'h0;
    end
    while (awvalid || wvalid || bready);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] v);
    q.push_back({a, v});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) rready <= 1'h0;
    end
    while (arvalid || rready);
  endtask : rd

  task automatic hdr(input logic g);
    @(posedge clk);
    send <= 1'h1;
    good <= g;
    @(posedge clk);
    send <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : hdr

  // One target byte on the tributary enable; the slots settle one cycle later.
  task automatic pulse_trib;
    tv <= 8'($urandom);
    ten <= 1'h1;
    @(posedge clk);
    ten <= 1'h0;
    @(posedge clk);
  endtask : pulse_trib

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // Hang guard, well above the length of the whole sequence.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'h87bd16a7));
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd(8'h14, {2'h0, 16'h0, 8'h05, 8'h01});
    rd(8'h10, {2'h0, 32'h0010_0100});
    rd(8'h18, {2'h2, 32'h0});
    $display("reset values done");
    sink <= 1'h1;
    rd(8'h14, {2'h0, 16'h0, 8'h05, 8'h09});
    sink <= 1'h0;
    $display("defect flag done");
    cur = 3'h1;
    for (int i = 0; i < 8; i++)
    begin
      c = 4'(i + 2);
      wr(8'h00, {25'h0, 3'(i), c});
      if (i == 1 || i > 4) cur = 3'(i);
      rd(8'h14, {2'h0, 16'h0, 8'h05, (c > 4'h8) ? 4'h0 : c, 1'h0, cur});
    end
    $display("status codes done");
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h08, pw[i]);
      psi_now = pe[i];
      rd(8'h14, {2'h0, 16'h0, psi_now, 4'h0, 1'h0, cur});
    end
    $display("payload labels done");
    for (int i = 0; i < 10; i++)
    begin
      x = {reqs[i], 28'($urandom)};
      wr(8'h04, x);
      rd(8'h04, {2'h0, x});
      check(8'h04, aps, x);
    end
    wr(8'h04, 32'h3000_0000);
    rd(8'h04, {2'h0, reqs[9], 28'h0});
    $display("protection requests done");
    wr(8'h10, 32'h0020_0100);
    hdr(1'h1);
    hdr(1'h0);
    hdr(1'h1);
    rd(8'h14, {2'h0, 16'h0, psi_now, 4'h0, 1'h0, cur});
    hdr(1'h1);
    rd(8'h14, {2'h0, 15'h0, 1'h1, psi_now, 4'h0, 1'h0, cur});
    $display("delineation done");
    pulse_trib();
    check(8'h0C, ts[7:0], tv);
    wr(8'h0C, 32'h0000_0100);
    pulse_trib();
    check(8'h0C, ts == {8{tv}}, 1'h1);
    $display("tributary done");
    cf <= 1'h1;
    repeat (2) @(posedge clk);
    check(8'hE2, {gi, gt}, 11'h2AA);
    cf <= 1'h0;
    wr(8'h10, 32'h0021_010C);
    @(posedge clk);
    check(8'h10, {mg, fe, gh}, 18'h39001);
    cf <= 1'h1;
    repeat (2) @(posedge clk);
    check(8'hE3, {gp, gi, gt}, 12'hC00);
    repeat (20) @(posedge clk);
    check(8'hE3, gp, 1'h1);
    $display("framing done");
    report_and_stop();
  end
endmodule : otn_overhead_gfp_mapper_tb
